// file: hw/ess_core.sv
// encoder speed supervision: quadrature edge counting, low speed hold and
// zero handling, encoder loss detection and a speed monitor filter
// assumes encoder pins and all settings are synchronous to clk_sys
`timescale 1ns/1ps

// Summary of operation
// - loss event after timeout at torque limit
// - zero timeout disables the loss event
// - first order monitor filter, 2 to 20000 ms
// - pulses evaluated once per 1 ms cycle
// - count both edges of A and B
// - on pulse recompute speed and proportional term
// - idle cycle holds speed and proportional term
// - after hold time proportional term forced zero
// - after zero delay speed cleared, proportional allowed
// - pulse before zero delay keeps speed
// - pulses within hold time force nothing
// - select bit: 1 fault, 0 alarm
module ess_core #(
  parameter int MS_CYCLES = ess_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic at_limit,
  input wire logic signed [ess_pkg::SPEED_W-1:0] speed_reference,
  input wire logic [ess_pkg::MS_W-1:0] loss_timeout_ms,
  input wire logic [ess_pkg::MS_W-1:0] speed_monitor_filter_constant,
  input wire logic [ess_pkg::MS_W-1:0] hold_time_ms,
  input wire logic [ess_pkg::MS_W-1:0] zero_delay_ms,
  input wire logic loss_response_select,
  output logic signed [ess_pkg::SPEED_W-1:0] measured_speed,
  output logic signed [ess_pkg::SPEED_W-1:0] p_term,
  output logic p_forced_zero,
  output logic speed_zero,
  output logic signed [ess_pkg::SPEED_W-1:0] filtered_speed_signal,
  output logic loss_alarm,
  output logic loss_fault,
  output logic meas_tick
);
  localparam int W = ess_pkg::SPEED_W;
  localparam int MW = ess_pkg::MS_W;
  localparam int AW = W + ess_pkg::FILT_FRAC;

  logic a_prev_reg, b_prev_reg;
  logic [31:0] div_reg;
  logic tick_reg;
  logic signed [W-1:0] edges_reg, edges_next;
  logic [MW-1:0] interval_reg, idle_reg, loss_ms_reg;
  logic signed [W-1:0] speed_reg, p_hold_reg, p_reg, filt_out_reg;
  logic p_zero_reg, zero_reg, alarm_reg, fault_reg;
  logic signed [AW-1:0] filt_acc_reg, filt_acc_next;

  // quadrature decode; a simultaneous change of both lines is dropped
  wire a_chg = enc_a ^ a_prev_reg;
  wire b_chg = enc_b ^ b_prev_reg;
  wire edge_seen = a_chg ^ b_chg;
  wire count_up = enc_a ^ b_prev_reg;
  wire tick = (div_reg == 32'(MS_CYCLES - 1));
  wire pulse_in_cycle = (edges_next != '0);
  wire signed [W-1:0] edge_step = count_up ? W'(1) : -W'(1);

  always_comb begin
    edges_next = edges_reg;
    if (edge_seen) begin
      edges_next = edges_reg + edge_step;
    end
  end

  // speed in edges per ms, scaled; divider is wide but spends one cycle
  wire [MW-1:0] interval_now = (interval_reg == ess_pkg::MS_SAT) ? interval_reg
                               : interval_reg + MW'(1);
  wire signed [31:0] edges_scaled = 32'(edges_next) <<< ess_pkg::SPEED_SHIFT;
  wire signed [31:0] speed_quot = edges_scaled / $signed({16'h0000, interval_now});
  wire signed [W-1:0] speed_calc = W'(speed_quot);
  wire signed [W-1:0] speed_err = speed_reference - speed_calc;
  wire [MW-1:0] idle_inc = (idle_reg == ess_pkg::MS_SAT) ? idle_reg : idle_reg + MW'(1);
  wire hold_over = (idle_inc >= hold_time_ms);
  wire zero_over = (idle_inc >= zero_delay_ms);

  // loss timer runs only while pinned at the limit with no edges
  wire [MW-1:0] loss_inc = (loss_ms_reg == ess_pkg::MS_SAT) ? loss_ms_reg
                           : loss_ms_reg + MW'(1);
  // gated by at_limit so leaving the limit drops the event at once, not a cycle late
  wire loss_enabled = (loss_timeout_ms != '0);
  wire loss_active = at_limit && loss_enabled && (loss_ms_reg >= loss_timeout_ms);

  // filter constant clamped into its legal range
  wire [MW-1:0] filt_t = (speed_monitor_filter_constant < ess_pkg::FILT_CONST_MIN)
                         ? ess_pkg::FILT_CONST_MIN
                         : (speed_monitor_filter_constant > ess_pkg::FILT_CONST_MAX)
                         ? ess_pkg::FILT_CONST_MAX : speed_monitor_filter_constant;
  wire signed [AW-1:0] filt_target = AW'(speed_reg) <<< ess_pkg::FILT_FRAC;
  wire signed [AW-1:0] filt_delta = (filt_target - filt_acc_reg) / $signed({1'b0, filt_t});
  assign filt_acc_next = filt_acc_reg + filt_delta;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      div_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else begin
      a_prev_reg <= enc_a;
      b_prev_reg <= enc_b;
      div_reg <= tick ? 32'h00000000 : div_reg + 32'h00000001;
      tick_reg <= tick;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      edges_reg <= '0;
      interval_reg <= '0;
      speed_reg <= '0;
      p_hold_reg <= '0;
      p_zero_reg <= 1'b0;
      zero_reg <= 1'b1;
    end else if (tick) begin
      edges_reg <= '0;
      if (pulse_in_cycle) begin
        interval_reg <= '0;
        speed_reg <= speed_calc;
        p_hold_reg <= speed_err;
        p_zero_reg <= 1'b0;
        zero_reg <= 1'b0;
      end else begin
        interval_reg <= interval_now;
        if (zero_over) begin
          speed_reg <= '0;
          // speed is now zero, so the allowed term is the full reference
          p_hold_reg <= speed_reference;
          p_zero_reg <= 1'b0;
          zero_reg <= 1'b1;
        end else if (hold_over) begin
          p_zero_reg <= 1'b1;
        end
      end
    end else begin
      edges_reg <= edges_next;
    end
  end

  // idle and loss timers restart on every counted edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      idle_reg <= '0;
      loss_ms_reg <= '0;
    end else begin
      if (edge_seen) begin
        idle_reg <= '0;
      end else if (tick) begin
        // the evaluating tick restarts the count, so hold and zero run in whole ms
        idle_reg <= pulse_in_cycle ? '0 : idle_inc;
      end
      if (edge_seen || !at_limit) begin
        loss_ms_reg <= '0;
      end else if (tick) begin
        loss_ms_reg <= loss_inc;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      p_reg <= '0;
      filt_acc_reg <= '0;
      filt_out_reg <= '0;
      alarm_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      p_reg <= p_zero_reg ? '0 : p_hold_reg;
      if (tick_reg) begin
        filt_acc_reg <= filt_acc_next;
        filt_out_reg <= W'(filt_acc_next >>> ess_pkg::FILT_FRAC);
      end
      alarm_reg <= loss_active && (loss_response_select == ess_pkg::LOSS_SEL_ALARM);
      fault_reg <= loss_active && (loss_response_select == ess_pkg::LOSS_SEL_FAULT);
    end
  end

  assign measured_speed = speed_reg;
  assign p_term = p_reg;
  assign p_forced_zero = p_zero_reg;
  assign speed_zero = zero_reg;
  assign filtered_speed_signal = filt_out_reg;
  assign loss_alarm = alarm_reg;
  assign loss_fault = fault_reg;
  assign meas_tick = tick_reg;

  property p_loss_raise;
    @(posedge clk_sys) disable iff (reset)
      (at_limit && loss_timeout_ms != '0 && loss_ms_reg >= loss_timeout_ms
       && $stable(loss_timeout_ms))
      |=> (loss_alarm || loss_fault);
  endproperty
  a_loss_raise: assert property (p_loss_raise) else $error("loss event missing");

  property p_loss_limit;
    @(posedge clk_sys) disable iff (reset)
      (loss_alarm || loss_fault) |-> $past(at_limit);
  endproperty
  a_loss_limit: assert property (p_loss_limit) else $error("loss event off the limit");

  property p_loss_off;
    @(posedge clk_sys) disable iff (reset)
      $past(loss_timeout_ms == '0) |-> !(loss_alarm || loss_fault);
  endproperty
  a_loss_off: assert property (p_loss_off) else $error("loss event while disabled");

  property p_edge_count;
    @(posedge clk_sys) disable iff (reset)
      (edge_seen && !tick) |=> (edges_reg != $past(edges_reg));
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("edge not counted");

  property p_pulse_update;
    @(posedge clk_sys) disable iff (reset)
      (tick && pulse_in_cycle) |=> (!p_forced_zero && !speed_zero) ##1 (p_term == p_hold_reg);
  endproperty
  a_pulse_update: assert property (p_pulse_update) else $error("pulse did not update");

  property p_idle_hold;
    @(posedge clk_sys) disable iff (reset)
      (tick && !pulse_in_cycle && !zero_over) |=> $stable(measured_speed);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("speed not held");

  property p_forced;
    @(posedge clk_sys) disable iff (reset)
      (tick && !pulse_in_cycle && hold_over && !zero_over) |=> p_forced_zero ##1 (p_term == '0);
  endproperty
  a_forced: assert property (p_forced) else $error("proportional term not forced");

  property p_zero_clear;
    @(posedge clk_sys) disable iff (reset)
      (tick && !pulse_in_cycle && zero_over) |=> (measured_speed == '0 && !p_forced_zero);
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("speed not cleared");

  property p_select;
    @(posedge clk_sys) disable iff (reset)
      (loss_fault |-> $past(loss_response_select)) and
      (loss_alarm |-> !$past(loss_response_select));
  endproperty
  a_select: assert property (p_select) else $error("wrong loss response");

  property p_restart;
    @(posedge clk_sys) disable iff (reset)
      edge_seen |=> (idle_reg == '0 && loss_ms_reg == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("timers not restarted");

  c_pulse: cover property (@(posedge clk_sys) disable iff (reset) tick && pulse_in_cycle);
  c_forced: cover property (@(posedge clk_sys) disable iff (reset) $rose(p_forced_zero));
  c_zero: cover property (@(posedge clk_sys) disable iff (reset) $rose(speed_zero));
  c_fault: cover property (@(posedge clk_sys) disable iff (reset) $rose(loss_fault));
endmodule : ess_core

// file: hw/ess_pkg.sv
// constants for the encoder speed supervision block
// assumes one 50 MHz system clock and a 1 ms measurement time base
package ess_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int MEAS_CYCLE_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * MEAS_CYCLE_MS;
  localparam int SPEED_W = 16;
  localparam int MS_W = 16;
  localparam int SPEED_SHIFT = 10;
  localparam int FILT_FRAC = 16;
  localparam logic [MS_W-1:0] LOSS_TIMEOUT_DEF = 16'h03E8;
  localparam logic [MS_W-1:0] LOSS_TIMEOUT_MAX = 16'hC350;
  localparam logic [MS_W-1:0] FILT_CONST_DEF = 16'h01F4;
  localparam logic [MS_W-1:0] FILT_CONST_MIN = 16'h0002;
  localparam logic [MS_W-1:0] FILT_CONST_MAX = 16'h4E20;
  localparam logic [MS_W-1:0] HOLD_TIME_DEF = 16'h0004;
  localparam logic [MS_W-1:0] ZERO_DELAY_DEF = 16'h00FA;
  localparam logic LOSS_SEL_FAULT = 1'b1;
  localparam logic LOSS_SEL_ALARM = 1'b0;
  localparam logic [MS_W-1:0] MS_SAT = 16'hFFFF;
endpackage : ess_pkg

// file: sim/ess_core_test.sv
// self-checking bench for ess_core with an encoder model
// assumes the 1 ms time base is shortened to 20 clocks
`timescale 1ns/1ps
module ess_core_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic step = 1'b0;
  logic enc_a, enc_b;
  logic at_limit = 1'b0;
  logic signed [15:0] speed_reference = 16'h2000;
  logic [15:0] loss_timeout_ms = 16'h0005;
  logic [15:0] speed_monitor_filter_constant = 16'h0002;
  logic [15:0] hold_time_ms = 16'h0004;
  logic [15:0] zero_delay_ms = 16'h0008;
  logic loss_response_select = 1'b0;
  logic signed [15:0] measured_speed, p_term, filtered_speed_signal;
  logic p_forced_zero, speed_zero, loss_alarm, loss_fault, meas_tick;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  ess_core #(.MS_CYCLES(20)) ess_core_inst (.clk_sys, .reset, .enc_a, .enc_b, .at_limit,
    .speed_reference, .loss_timeout_ms, .speed_monitor_filter_constant, .hold_time_ms,
    .zero_delay_ms, .loss_response_select, .measured_speed, .p_term, .p_forced_zero,
    .speed_zero, .filtered_speed_signal, .loss_alarm, .loss_fault, .meas_tick);
  ess_enc_model ess_enc_model_inst (.clk_sys(clk_sys), .step(step), .enc_a(enc_a),
    .enc_b(enc_b));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // a hung wait ends the run instead of stalling the simulator
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check16
  task automatic check1(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : check1
  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (meas_tick !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
    end
  endtask : wait_tick
  task automatic pulse(input int n);
    step = 1'b1;
    repeat (n) @(negedge clk_sys);
    step = 1'b0;
  endtask : pulse
  initial begin
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    check16("speed_rst", 16'h0000, measured_speed);
    check1("zero_rst", 1'b1, speed_zero);
    // long steady run so the monitor filter settles near the speed
    repeat (24) begin
      pulse(1);
      wait_tick();
    end
    check16("speed_one", 16'h0400, measured_speed);
    check1("pfz_one", 1'b0, p_forced_zero);
    @(negedge clk_sys);
    check16("p_one", 16'h1C00, p_term);
    check1("filt", 1'b1, filtered_speed_signal inside {[16'sd1000:16'sd1024]});
    pulse(4);
    wait_tick();
    check16("speed_four", 16'h1000, measured_speed);
    for (int i = 1; i <= 8; i++) begin
      wait_tick();
      check16("speed_idle", (i < 8) ? 16'h1000 : 16'h0000, measured_speed);
      check1("pfz_idle", i >= 4 && i < 8, p_forced_zero);
      check1("zero_idle", i >= 8, speed_zero);
      @(negedge clk_sys);
      check1("tick_low", 1'b0, meas_tick);
      check16("p_idle", (i < 4) ? 16'h1000 : (i < 8) ? 16'h0000 : 16'h2000, p_term);
    end
    repeat (2) begin
      pulse(1);
      wait_tick();
    end
    repeat (5) wait_tick();
    check1("pfz_gap", 1'b1, p_forced_zero);
    pulse(1);
    wait_tick();
    check16("speed_gap", 16'h00AA, measured_speed);
    repeat (3) wait_tick();
    check1("zero_gap", 1'b0, speed_zero);
    check16("speed_kept", 16'h00AA, measured_speed);
    pulse(1);
    at_limit = 1'b1;
    repeat (4) wait_tick();
    check1("alarm_early", 1'b0, loss_alarm);
    repeat (2) wait_tick();
    check1("alarm", 1'b1, loss_alarm);
    check1("no_fault", 1'b0, loss_fault);
    loss_response_select = 1'b1;
    repeat (2) @(negedge clk_sys);
    check1("fault", 1'b1, loss_fault);
    check1("no_alarm", 1'b0, loss_alarm);
    pulse(1);
    repeat (3) @(negedge clk_sys);
    check1("fault_clr", 1'b0, loss_fault);
    loss_timeout_ms = 16'h0000;
    repeat (8) wait_tick();
    check1("fault_off", 1'b0, loss_fault);
    loss_timeout_ms = 16'h0005;
    at_limit = 1'b0;
    @(negedge clk_sys);
    check1("fault_drop", 1'b0, loss_fault);
    repeat (8) wait_tick();
    check1("fault_nolim", 1'b0, loss_fault);
    close_out();
  end
endmodule : ess_core_test

// file: sim/ess_enc_model.sv
// quadrature encoder model: one edge per clock while step is high
// assumes forward rotation only, channel a leading b
`timescale 1ns/1ps
module ess_enc_model (
  input wire logic clk_sys,
  input wire logic step,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] st_reg = 2'h0;
  // gray order 00,10,11,01 so only one line changes per edge
  assign enc_a = st_reg[1] ^ st_reg[0];
  assign enc_b = st_reg[1];
  always_ff @(posedge clk_sys) begin
    if (step) begin
      st_reg <= st_reg + 2'h1;
    end
  end
endmodule : ess_enc_model
